// ### servo_fault_pkg.sv
`default_nettype none
package servo_fault_pkg;
    // ------------------------------------------------------------
    // Fault flag positions
    // ------------------------------------------------------------
    localparam int FLAG_N      = 8;
    localparam int F_DRV_INIT  = 0;
    localparam int F_FB_INIT   = 1;
    localparam int F_EEPROM    = 2;
    localparam int F_COMM_FAIL = 3;
    localparam int F_SYNC      = 4;
    localparam int F_MAX_SPEED = 5;
    localparam int F_SAME_OVER = 6;
    localparam int F_REV_OVER  = 7;

    // ------------------------------------------------------------
    // Display codes
    // ------------------------------------------------------------
    localparam logic [15:0] CODE_NONE      = 16'h0000;
    localparam logic [15:0] CODE_SYNC      = 16'h7582;
    localparam logic [15:0] CODE_DRV_INIT  = 16'h7590;
    localparam logic [15:0] CODE_EEPROM    = 16'h7592;
    localparam logic [15:0] CODE_SAME_OVER = 16'h8480;
    localparam logic [15:0] CODE_MAX_SPEED = 16'h8482;

    // ------------------------------------------------------------
    // Loop timing and limits
    // ------------------------------------------------------------
    localparam logic [15:0] CUR_LOOP_SINGLE_US = 16'h0064; // 100 us
    localparam logic [15:0] CUR_LOOP_DOUBLE_US = 16'h0032; // 50 us
    localparam logic [3:0]  SPEED_LOOP_MIN     = 4'h3;
    localparam logic [3:0]  SPEED_LOOP_MAX     = 4'h5;
    localparam logic [3:0]  SAME_LIMIT_NUM     = 4'h6;     // 120 % = 6/5
    localparam logic [3:0]  REV_LIMIT_NUM      = 4'h1;     // 20 % = 1/5
    localparam logic [3:0]  LIMIT_DEN          = 4'h5;

    // ------------------------------------------------------------
    // Selections
    // ------------------------------------------------------------
    localparam logic        NODE_SEL_BUS       = 1'b1;
    localparam logic [1:0]  PROTO_FIELDBUS     = 2'h1;
endpackage
`default_nettype wire

// ### speed_fault_if.sv
`default_nettype none
interface speed_fault_if;
    logic same_hit;   // Same-direction overspeed seen
    logic rev_hit;    // Reverse overspeed seen
    logic max_hit;    // Maximum speed held too long
    modport checker_mp (output same_hit, output rev_hit, output max_hit);
    modport monitor_mp (input same_hit, input rev_hit, input max_hit);
endinterface
`default_nettype wire

// ### speed_fault_check.sv
`default_nettype none
module speed_fault_check #(
    parameter int SPEED_W = 32
) (
    input  wire logic                  mclk_in,
    input  wire logic                  rst_in,
    input  wire logic signed [SPEED_W-1:0] act_speed_in,
    input  wire logic signed [SPEED_W-1:0] cmd_speed_in,
    input  wire logic [15:0]           rated_speed_in,
    input  wire logic [15:0]           max_speed_in,
    input  wire logic [15:0]           alarm_cycles_in,
    speed_fault_if.checker_mp          flt
);
    localparam int EW = SPEED_W + 1;
    localparam int PW = EW + 4;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (SPEED_W < 17 || SPEED_W > 48)
    begin : g_bad_width
        $error("speed_fault_check: SPEED_W must lie in 17..48");
    end

    // Magnitude of a signed value one bit wider than speed
    function automatic logic [EW-1:0] mag(input logic signed [EW-1:0] v);
        mag = v[EW-1] ? EW'(-v) : EW'(v);
    endfunction

    logic [EW-1:0] err_mag;
    logic [EW-1:0] act_mag;
    logic          same_dir;
    logic          same_over;
    logic          rev_over;
    logic          over_max;
    logic [15:0]   over_cnt_reg;

    // ------------------------------------------------------------
    // Speed error and limits
    // ------------------------------------------------------------
    assign err_mag   = mag(EW'(cmd_speed_in) - EW'(act_speed_in));
    assign act_mag   = mag(EW'(act_speed_in));
    assign same_dir  = act_speed_in[SPEED_W-1] == cmd_speed_in[SPEED_W-1];
    assign same_over = same_dir && (PW'(err_mag) * PW'(servo_fault_pkg::LIMIT_DEN)
                       > PW'(rated_speed_in) * PW'(servo_fault_pkg::SAME_LIMIT_NUM));
    assign rev_over  = !same_dir && (PW'(err_mag) * PW'(servo_fault_pkg::LIMIT_DEN)
                       > PW'(rated_speed_in) * PW'(servo_fault_pkg::REV_LIMIT_NUM));
    assign over_max  = act_mag > EW'(max_speed_in);

    // Direction overspeed flags
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            flt.same_hit <= 1'b0;
            flt.rev_hit  <= 1'b0;
        end
        else
        begin
            flt.same_hit <= same_over;
            flt.rev_hit  <= rev_over;
        end
    end

    // Time spent above maximum speed
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            over_cnt_reg <= 16'h0000;
        else if (!over_max)
            over_cnt_reg <= 16'h0000;
        else if (over_cnt_reg != 16'hFFFF)
            over_cnt_reg <= over_cnt_reg + 16'h0001;
    end

    // Maximum speed fault after alarm duration
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            flt.max_hit <= 1'b0;
        else
            flt.max_hit <= over_max && (over_cnt_reg > alarm_cycles_in);
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    property p_same_over;
        same_over |=> flt.same_hit;
    endproperty
    a_same_over: assert property (p_same_over) else $error("same overspeed missed");

    property p_rev_over;
        rev_over |=> flt.rev_hit && !flt.same_hit;
    endproperty
    a_rev_over: assert property (p_rev_over) else $error("reverse overspeed missed");

    property p_max_only_after_hold;
        flt.max_hit |-> $past(over_max) && $past(over_cnt_reg) > $past(alarm_cycles_in);
    endproperty
    a_max_only_after_hold: assert property (p_max_only_after_hold)
        else $error("max speed fault without hold");

    property p_max_drops;
        !over_max |=> !flt.max_hit;
    endproperty
    a_max_drops: assert property (p_max_drops) else $error("max speed fault stuck");

    c_same: cover property (flt.same_hit);
    c_max:  cover property (over_max [*4] ##1 flt.max_hit);
endmodule
`default_nettype wire

// ### servo_fault_monitor.sv
`default_nettype none
module servo_fault_monitor #(
    parameter int          SPEED_W       = 32,
    parameter logic [15:0] CODE_FB_INIT  = 16'h0001,
    parameter logic [15:0] CODE_REV_OVER = 16'h0002,
    parameter logic [15:0] CODE_COMM     = 16'h0003
) (
    input  wire logic                      mclk_in,
    input  wire logic                      rst_in,
    input  wire logic                      host_ctrl_in,
    input  wire logic [15:0]               bus_cycle_us_in,
    input  wire logic [3:0]                speed_loop_count_in,
    input  wire logic                      double_sided_in,
    input  wire logic                      drive_init_fail_in,
    input  wire logic                      fb_init_fail_in,
    input  wire logic                      eeprom_done_in,
    input  wire logic                      eeprom_err_in,
    input  wire logic                      node_number_config_select_in,
    input  wire logic [1:0]                comm_protocol_select_in,
    input  wire logic                      node_write_want_in,
    input  wire logic                      enable_in,
    input  wire logic                      link_ok_in,
    input  wire logic signed [SPEED_W-1:0] act_speed_in,
    input  wire logic signed [SPEED_W-1:0] cmd_speed_in,
    input  wire logic [15:0]               rated_speed_in,
    input  wire logic [15:0]               max_speed_in,
    input  wire logic [15:0]               alarm_cycles_in,
    input  wire logic                      clear_in,
    output logic [7:0]                     fault_flags_out,
    output logic [15:0]                    fault_code_out,
    output logic                           fault_any_out,
    output logic                           node_write_req_out,
    output logic                           count_advice_out
);
    // ------------------------------------------------------------
    // Local sizes
    // ------------------------------------------------------------
    localparam int LOOP_W = 20;
    localparam int FN     = servo_fault_pkg::FLAG_N;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (SPEED_W < 17 || SPEED_W > 48)
    begin : g_bad_speed_w
        $error("servo_fault_monitor: SPEED_W must lie in 17..48");
    end

    if (FN != 8)
    begin : g_bad_flag_n
        $error("servo_fault_monitor: flag vector must be eight bits");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [LOOP_W-1:0] cur_loop_us;
    logic [LOOP_W-1:0] speed_loop_us;
    logic [LOOP_W-1:0] bus_rem;
    logic              loop_zero;
    logic              sync_bad;
    logic              count_bad;
    logic              fb_init_bad;
    logic              eeprom_bad;
    logic              link_bad;
    logic [FN-1:0]     set_vec;
    logic [FN-1:0]     flags_next;

    // Speed fault results from the checker
    speed_fault_if     flt_bus ();

    // ------------------------------------------------------------
    // Code decoding
    // ------------------------------------------------------------

    // Display code of one fault flag
    function automatic logic [15:0] code_for_bit(input int idx);
        case (idx)
            servo_fault_pkg::F_DRV_INIT:  code_for_bit = servo_fault_pkg::CODE_DRV_INIT;
            servo_fault_pkg::F_FB_INIT:   code_for_bit = CODE_FB_INIT;
            servo_fault_pkg::F_EEPROM:    code_for_bit = servo_fault_pkg::CODE_EEPROM;
            servo_fault_pkg::F_COMM_FAIL: code_for_bit = CODE_COMM;
            servo_fault_pkg::F_SYNC:      code_for_bit = servo_fault_pkg::CODE_SYNC;
            servo_fault_pkg::F_MAX_SPEED: code_for_bit = servo_fault_pkg::CODE_MAX_SPEED;
            servo_fault_pkg::F_SAME_OVER: code_for_bit = servo_fault_pkg::CODE_SAME_OVER;
            servo_fault_pkg::F_REV_OVER:  code_for_bit = CODE_REV_OVER;
            default:                      code_for_bit = servo_fault_pkg::CODE_NONE;
        endcase
    endfunction

    // Lowest flag index wins the display
    function automatic logic [15:0] code_of(input logic [FN-1:0] f);
        code_of = servo_fault_pkg::CODE_NONE;
        for (int i = FN - 1; i >= 0; i--)
        begin
            if (f[i])
                code_of = code_for_bit(i);
        end
    endfunction

    // ------------------------------------------------------------
    // Loop timing
    // ------------------------------------------------------------

    // Current loop period from modulation mode
    assign cur_loop_us   = double_sided_in ? LOOP_W'(servo_fault_pkg::CUR_LOOP_DOUBLE_US)
                                           : LOOP_W'(servo_fault_pkg::CUR_LOOP_SINGLE_US);
    assign speed_loop_us = cur_loop_us * LOOP_W'(speed_loop_count_in);

    // Zero count would divide by zero, so it faults too
    assign loop_zero = speed_loop_us == 20'h00000;
    assign bus_rem   = loop_zero ? 20'h00000 : LOOP_W'(bus_cycle_us_in) % speed_loop_us;
    assign sync_bad  = host_ctrl_in && (loop_zero || bus_rem != 20'h00000);

    // Count outside the advised range
    assign count_bad = speed_loop_count_in < servo_fault_pkg::SPEED_LOOP_MIN
                    || speed_loop_count_in > servo_fault_pkg::SPEED_LOOP_MAX;

    // ------------------------------------------------------------
    // Communication faults
    // ------------------------------------------------------------

    // Wrong protocol selection also fails bus start-up
    assign fb_init_bad = fb_init_fail_in
                      || comm_protocol_select_in != servo_fault_pkg::PROTO_FIELDBUS;
    assign eeprom_bad  = eeprom_done_in && eeprom_err_in;
    assign link_bad    = enable_in && !link_ok_in;

    // Fault events of this cycle
    always_comb
    begin
        set_vec = '0;
        set_vec[servo_fault_pkg::F_DRV_INIT]  = drive_init_fail_in;
        set_vec[servo_fault_pkg::F_FB_INIT]   = fb_init_bad;
        set_vec[servo_fault_pkg::F_EEPROM]    = eeprom_bad;
        set_vec[servo_fault_pkg::F_COMM_FAIL] = link_bad;
        set_vec[servo_fault_pkg::F_SYNC]      = sync_bad;
        set_vec[servo_fault_pkg::F_MAX_SPEED] = flt_bus.max_hit;
        set_vec[servo_fault_pkg::F_SAME_OVER] = flt_bus.same_hit;
        set_vec[servo_fault_pkg::F_REV_OVER]  = flt_bus.rev_hit;
    end

    // ------------------------------------------------------------
    // Speed checks
    // ------------------------------------------------------------

    // Overspeed and maximum speed detection
    speed_fault_check #(
        .SPEED_W         (SPEED_W)
    ) speed_fault_check_inst (
        .mclk_in         (mclk_in),
        .rst_in          (rst_in),
        .act_speed_in    (act_speed_in),
        .cmd_speed_in    (cmd_speed_in),
        .rated_speed_in  (rated_speed_in),
        .max_speed_in    (max_speed_in),
        .alarm_cycles_in (alarm_cycles_in),
        .flt             (flt_bus)
    );

    // ------------------------------------------------------------
    // Fault latches
    // ------------------------------------------------------------

    // Set beats clear when both come together
    for (genvar g = 0; g < FN; g++)
    begin : g_flag
        assign flags_next[g] = (clear_in ? 1'b0 : fault_flags_out[g]) | set_vec[g];
    end

    // Latched flags
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            fault_flags_out <= 8'h00;
        else
            fault_flags_out <= flags_next;
    end

    // Display code and summary, in step with the flags
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            fault_code_out <= servo_fault_pkg::CODE_NONE;
            fault_any_out  <= 1'b0;
        end
        else
        begin
            fault_code_out <= code_of(flags_next);
            fault_any_out  <= |flags_next;
        end
    end

    // ------------------------------------------------------------
    // Host side outputs
    // ------------------------------------------------------------

    // Node number write only when not bus configured
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            node_write_req_out <= 1'b0;
        else
            node_write_req_out <= node_write_want_in
                && node_number_config_select_in != servo_fault_pkg::NODE_SEL_BUS;
    end

    // Advice to pick another speed loop count
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            count_advice_out <= 1'b0;
        else
            count_advice_out <= count_bad;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    property p_sync_flag;
        sync_bad |=> fault_flags_out[servo_fault_pkg::F_SYNC];
    endproperty
    a_sync_flag: assert property (p_sync_flag) else $error("sync fault missed");

    property p_eeprom_flag;
        eeprom_done_in && eeprom_err_in |=> fault_flags_out[servo_fault_pkg::F_EEPROM];
    endproperty
    a_eeprom_flag: assert property (p_eeprom_flag) else $error("eeprom fault missed");

    property p_comm_flag;
        enable_in && !link_ok_in |=> fault_flags_out[servo_fault_pkg::F_COMM_FAIL];
    endproperty
    a_comm_flag: assert property (p_comm_flag) else $error("link fault missed");

    property p_latch_hold;
        !clear_in |=> (fault_flags_out & $past(fault_flags_out)) == $past(fault_flags_out);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("fault flag lost");

    property p_node_block;
        node_number_config_select_in == servo_fault_pkg::NODE_SEL_BUS |=> !node_write_req_out;
    endproperty
    a_node_block: assert property (p_node_block) else $error("node write not blocked");

    property p_any_match;
        fault_any_out == (fault_flags_out != 8'h00);
    endproperty
    a_any_match: assert property (p_any_match) else $error("summary flag wrong");

    c_sync_fault: cover property (sync_bad ##1 fault_flags_out[servo_fault_pkg::F_SYNC]);
    c_clear:      cover property (fault_any_out ##1 clear_in ##1 !fault_any_out);
endmodule
`default_nettype wire

// ### fb_master_model.sv
`default_nettype none
module fb_master_model (
    input  wire logic        mclk_in,
    input  wire logic [15:0] bus_in,
    input  wire logic [3:0]  cnt_in,
    output logic             host_out,
    output logic [15:0]      bus_out,
    output logic [3:0]       cnt_out,
    output logic [1:0]       proto_out,
    output logic             node_sel_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Fixed host setup, bus configured node number
    initial
    begin
        host_out = 1'b1;
        proto_out = servo_fault_pkg::PROTO_FIELDBUS;
        node_sel_out = servo_fault_pkg::NODE_SEL_BUS;
        bus_out = 16'h03E8;
        cnt_out = 4'h5;
    end
    // Cycle settings change just after an edge
    always @(posedge mclk_in)
    begin
        bus_out <= #1 bus_in;
        cnt_out <= #1 cnt_in;
    end
endmodule
`default_nettype wire

// ### servo_fault_monitor_bench.sv
`default_nettype none
module servo_fault_monitor_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int bus; int cnt; int dbl; int ev; int act; int cmd; int flg; int code;} row_type;
    logic               mclk_in = 1'b0;
    logic               rst_in = 1'b1;
    logic [15:0]        bus_cyc = 16'h03E8;
    logic [3:0]         cnt = 4'h5;
    logic               dbl = 1'b0;
    logic [3:0]         ev = 4'h0;
    logic               clr = 1'b0;
    logic               want = 1'b0;
    logic signed [31:0] act = 32'sh0;
    logic signed [31:0] cmd = 32'sh0;
    logic               host, nsel, any, nreq, adv;
    logic [15:0]        bus_m, code;
    logic [3:0]         cnt_m;
    logic [1:0]         proto;
    logic [7:0]         flags;
    int                 errors = 0;
    int                 checks = 0;
    // Inputs beside expected flags and display code
    row_type rows [12] = '{
        '{1000, 5, 0, 0, 0, 0, 8'h00, 16'h0000}, '{1000, 3, 0, 0, 0, 0, 8'h10, 16'h7582},
        '{600, 4, 1, 0, 0, 0, 8'h00, 16'h0000}, '{600, 4, 0, 0, 0, 0, 8'h10, 16'h7582},
        '{1000, 5, 0, 1, 0, 0, 8'h01, 16'h7590}, '{1000, 5, 0, 2, 0, 0, 8'h02, 16'h0001},
        '{1000, 5, 0, 4, 0, 0, 8'h04, 16'h7592}, '{1000, 5, 0, 8, 0, 0, 8'h08, 16'h0003},
        '{1000, 5, 0, 0, 1500, 100, 8'h40, 16'h8480}, '{1000, 5, 0, 0, 1100, 100, 8'h00, 16'h0000},
        '{1000, 5, 0, 0, -500, 100, 8'h80, 16'h0002}, '{1000, 5, 0, 0, 3500, 3400, 8'h20, 16'h8482}};
    fb_master_model fb_master_model_inst (.mclk_in(mclk_in), .bus_in(bus_cyc), .cnt_in(cnt),
        .host_out(host), .bus_out(bus_m), .cnt_out(cnt_m), .proto_out(proto),
        .node_sel_out(nsel));
    servo_fault_monitor servo_fault_monitor_inst (.mclk_in(mclk_in), .rst_in(rst_in),
        .host_ctrl_in(host), .bus_cycle_us_in(bus_m), .speed_loop_count_in(cnt_m),
        .double_sided_in(dbl), .drive_init_fail_in(ev[0]), .fb_init_fail_in(ev[1]),
        .eeprom_done_in(ev[2]), .eeprom_err_in(ev[2]), .node_number_config_select_in(nsel),
        .comm_protocol_select_in(proto), .node_write_want_in(want), .enable_in(1'b1),
        .link_ok_in(~ev[3]), .act_speed_in(act), .cmd_speed_in(cmd),
        .rated_speed_in(16'h03E8), .max_speed_in(16'h0BB8), .alarm_cycles_in(16'h0008),
        .clear_in(clr), .fault_flags_out(flags), .fault_code_out(code), .fault_any_out(any),
        .node_write_req_out(nreq), .count_advice_out(adv));
    // Clock, 20 ns period
    initial
    begin
        forever #10 mclk_in = ~mclk_in;
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic clear_all;
        ev = 4'h0;
        act = 32'sh0;
        cmd = 32'sh0;
        bus_cyc = 16'h03E8;
        cnt = 4'h5;
        step(3);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        step(1);
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        step(16);
        rst_in = 1'b0;
        step(1);
        check(16'(flags), 16'h0000);
        foreach (rows[i])
        begin
            bus_cyc = 16'(rows[i].bus);
            cnt = 4'(rows[i].cnt);
            dbl = 1'(rows[i].dbl);
            ev = 4'(rows[i].ev);
            act = rows[i].act;
            cmd = rows[i].cmd;
            for (int k = 0; k < 40 && flags !== 8'(rows[i].flg); k++) step(1);
            check(16'(flags), 16'(rows[i].flg));
            check(code, 16'(rows[i].code));
            clear_all();
            $display("row %0d done", i);
        end
        ev = 4'h1;
        step(1);
        ev = 4'h0;
        step(20);
        check(16'(flags), 16'h0001);
        check(16'(any), 16'h0001);
        clear_all();
        check(16'(flags), 16'h0000);
        $display("latch test done");
        act = 32'sd3500;
        cmd = 32'sd3400;
        step(4);
        act = 32'sh0;
        cmd = 32'sh0;
        step(3);
        check(16'(flags), 16'h0000);
        $display("short overspeed test done");
        check(16'(adv), 16'h0000);
        cnt = 4'h2;
        step(3);
        check(16'(adv), 16'h0001);
        clear_all();
        $display("count advice test done");
        want = 1'b1;
        step(2);
        check(16'(nreq), 16'h0000);
        $display("node write test done");
        print_verdict();
    end
endmodule
`default_nettype wire
